// ---- hdl/sbs_pkg.sv ----
package sbs_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ADDR_W = 18;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int SLEEP_ENTRY_MAX_NS = 200;
	localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_MAX_NS / CLK_PERIOD_NS;
	localparam int SLEEP_RECOVERY_MIN_NS = 200;
	localparam int SLEEP_RECOVERY_CYC = (SLEEP_RECOVERY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES = 3;
	// Host waits out the device's synchroniser as well as the recovery
	localparam int HOST_WAKE_CYC = SLEEP_RECOVERY_CYC + SYNC_STAGES + 1;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0] BEAT_RESET = 2'h0;
	localparam logic [2:0] COUNT_RESET = 3'h0;
	localparam logic [2:0] SYNC_RESET = 3'h0;

	// ----------------------------------------
	// States
	// ----------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_PROC = 7'h02,
		ST_READ = 7'h04,
		ST_WRITE = 7'h08,
		ST_ENTER = 7'h10,
		ST_SLEEP = 7'h20,
		ST_WAKE = 7'h40
	} sbs_dev_state_t;

	typedef enum logic [5:0] {
		H_IDLE = 6'h01,
		H_RD = 6'h02,
		H_WR = 6'h04,
		H_DESEL = 6'h08,
		H_SLEEP = 6'h10,
		H_RECOVER = 6'h20
	} sbs_host_state_t;

endpackage : sbs_pkg

// ---- hdl/sbs_bus_if.sv ----
`timescale 1ns/100ps
interface sbs_bus_if;
	logic [sbs_pkg::ADDR_W-1:0] addr;
	logic ctrlAddrStrobeN;
	logic procAddrStrobeN;
	logic burstAdvanceN;
	logic primaryChipSelN;
	logic secondaryChipSel;
	logic tertiaryChipSelN;
	logic wholeWordWriteN;
	logic laneWriteEnableN;
	logic [sbs_pkg::LANES-1:0] laneSelectN;
	logic burstLinear;
	logic outEnableN;
	logic sleepRequest;
	logic [sbs_pkg::DATA_W-1:0] hostData;
	logic hostDataOe;
	logic [sbs_pkg::DATA_W-1:0] devData;
	logic devDataOe;
	logic [sbs_pkg::DATA_W-1:0] sharedDataLines;

	// ----------------------------------------
	// Wire level of the common data lines
	// ----------------------------------------
	// Idle lines read as zero; no tri-state inside the model
	assign sharedDataLines = hostDataOe ? hostData : (devDataOe ? devData : '0);

	modport dev(
		input addr, ctrlAddrStrobeN, procAddrStrobeN, burstAdvanceN, primaryChipSelN,
		input secondaryChipSel, tertiaryChipSelN, wholeWordWriteN, laneWriteEnableN,
		input laneSelectN, burstLinear, outEnableN, sleepRequest, sharedDataLines,
		output devData, devDataOe
	);

	modport host(
		output addr, ctrlAddrStrobeN, procAddrStrobeN, burstAdvanceN, primaryChipSelN,
		output secondaryChipSel, tertiaryChipSelN, wholeWordWriteN, laneWriteEnableN,
		output laneSelectN, burstLinear, outEnableN, sleepRequest, hostData, hostDataOe,
		input sharedDataLines
	);
endinterface : sbs_bus_if

// ---- hdl/sbs_burst_ctr.sv ----
`timescale 1ns/100ps
module sbs_burst_ctr (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic load,
	input wire logic [1:0] start,
	input wire logic advance,
	input wire logic linear,
	output logic [1:0] nextOffset
);
	logic [1:0] start_q;
	logic [1:0] count_q;
	logic [1:0] countInc;

	// ----------------------------------------
	// Two-bit wraparound count
	// ----------------------------------------
	assign countInc = count_q + 2'h1;
	assign nextOffset = linear ? (start_q + countInc) : (start_q ^ countInc);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			start_q <= sbs_pkg::BEAT_RESET;
			count_q <= sbs_pkg::BEAT_RESET;
		end else if (load) begin
			start_q <= start;
			count_q <= sbs_pkg::BEAT_RESET;
		end else if (advance) begin
			count_q <= countInc;
		end
	end
endmodule : sbs_burst_ctr

// ---- hdl/sbs_sram_end.sv ----
// What this block does
// - Controller strobe with write bits begins write
// - Controller strobe ignored while processor strobe low
// - Strobe loads address register and burst counter
// - Advance ignored in controller-strobe load cycle
// - Global write all lanes, byte write selected
// - Any write cycle floats data outputs
// - Host raises output enable before driving data
// - Two-bit wrapping counter, linear or interleaved
// - Advance low steps counter, reads and writes
// - Disabled chip with strobe deselects, floats
// - Enabled chip with strobe begins read
// - Read burst advance low reads next address
// - Read burst advance high rereads current address
// - Write after processor strobe begins at current
// - Write burst advance low writes next address
// - Write burst advance high rewrites current address
// - Output enable gates data lines combinationally
// - Sleep input ignores inputs, floats data
// - Sleep entry and exit take two cycles
// - Contents kept; pending access dropped on sleep
// - Host deselects before asserting sleep
// - Host keeps strobes, enables idle after sleep
// - Processor strobe: write decided next clock rise
// - Processor strobe ignored with primary enable high
`timescale 1ns/100ps
module sbs_sram_end (
	input wire logic ref_clk,
	input wire logic rstn,
	sbs_bus_if.dev bus,
	output logic [sbs_pkg::ADDR_W-1:0] arrayAddr,
	output logic [sbs_pkg::LANES-1:0] arrayLaneWe,
	output logic [sbs_pkg::DATA_W-1:0] arrayWrData,
	input wire logic [sbs_pkg::DATA_W-1:0] arrayRdData,
	output logic sleeping
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	sbs_pkg::sbs_dev_state_t state_q;
	sbs_pkg::sbs_dev_state_t state_d;
	logic [2:0] sleepSync_q;
	logic sleepLvl_q;
	logic [2:0] modeSync_q;
	logic modeLinear_q;
	logic [2:0] phase_q;
	logic [sbs_pkg::ADDR_W-1:0] arrayAddr_q;
	logic [sbs_pkg::LANES-1:0] arrayLaneWe_q;
	logic [sbs_pkg::DATA_W-1:0] arrayWrData_q;
	logic drive_q;
	logic sleeping_q;
	logic chipOn;
	logic procStrobe;
	logic ctrlStrobe;
	logic writeSel;
	logic [sbs_pkg::LANES-1:0] lanes;
	logic load;
	logic advance;
	logic wrEn;
	logic drive;
	logic [1:0] nextOffset;

	// ----------------------------------------
	// Input decode
	// ----------------------------------------
	assign chipOn = ~bus.primaryChipSelN & bus.secondaryChipSel & ~bus.tertiaryChipSelN;
	assign procStrobe = ~bus.procAddrStrobeN & ~bus.primaryChipSelN;
	assign ctrlStrobe = ~bus.ctrlAddrStrobeN & ~procStrobe;
	assign writeSel = ~bus.wholeWordWriteN | (~bus.laneWriteEnableN & ~(&bus.laneSelectN));

	always_comb begin
		if (!bus.wholeWordWriteN) begin
			lanes = '1;
		end else if (!bus.laneWriteEnableN) begin
			lanes = ~bus.laneSelectN;
		end else begin
			lanes = '0;
		end
	end

	// ----------------------------------------
	// Cycle decode
	// ----------------------------------------
	// Only a load edge can bring a new strobe; anything else continues or suspends
	always_comb begin
		load = 1'b0;
		advance = 1'b0;
		wrEn = 1'b0;
		drive = 1'b0;
		state_d = state_q;
		unique case (state_q)
			sbs_pkg::ST_ENTER: begin
				if (phase_q == 3'(sbs_pkg::SLEEP_ENTRY_CYC - 1)) begin
					state_d = sbs_pkg::ST_SLEEP;
				end
			end
			sbs_pkg::ST_SLEEP: begin
				if (!sleepLvl_q) begin
					state_d = sbs_pkg::ST_WAKE;
				end
			end
			sbs_pkg::ST_WAKE: begin
				if (phase_q == 3'(sbs_pkg::SLEEP_RECOVERY_CYC - 1)) begin
					state_d = sbs_pkg::ST_IDLE;
				end
			end
			sbs_pkg::ST_IDLE, sbs_pkg::ST_PROC, sbs_pkg::ST_READ, sbs_pkg::ST_WRITE: begin
				if (sleepLvl_q) begin
					state_d = sbs_pkg::ST_ENTER;
				end else if (procStrobe) begin
					if (chipOn) begin
						load = 1'b1;
						drive = 1'b1;
						state_d = sbs_pkg::ST_PROC;
					end else begin
						state_d = sbs_pkg::ST_IDLE;
					end
				end else if (ctrlStrobe) begin
					if (chipOn) begin
						load = 1'b1;
						wrEn = writeSel;
						drive = ~writeSel;
						state_d = writeSel ? sbs_pkg::ST_WRITE : sbs_pkg::ST_READ;
					end else begin
						state_d = sbs_pkg::ST_IDLE;
					end
				end else if (state_q != sbs_pkg::ST_IDLE) begin
					advance = ~bus.burstAdvanceN;
					wrEn = writeSel;
					drive = ~writeSel;
					state_d = writeSel ? sbs_pkg::ST_WRITE : sbs_pkg::ST_READ;
				end
			end
		endcase
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Sleep and mode are asynchronous pins; a level counts once stages two and three agree
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sleepSync_q <= sbs_pkg::SYNC_RESET;
			sleepLvl_q <= 1'b0;
		end else begin
			sleepSync_q <= {sleepSync_q[1:0], bus.sleepRequest};
			if (sleepSync_q[1] == sleepSync_q[2]) begin
				sleepLvl_q <= sleepSync_q[2];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			modeSync_q <= sbs_pkg::SYNC_RESET;
			modeLinear_q <= 1'b0;
		end else begin
			modeSync_q <= {modeSync_q[1:0], bus.burstLinear};
			if (modeSync_q[1] == modeSync_q[2]) begin
				modeLinear_q <= modeSync_q[2];
			end
		end
	end

	// ----------------------------------------
	// State and sleep timing
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= sbs_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			phase_q <= sbs_pkg::COUNT_RESET;
		end else if (state_d != state_q) begin
			phase_q <= sbs_pkg::COUNT_RESET;
		end else begin
			phase_q <= phase_q + 3'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sleeping_q <= 1'b0;
		end else begin
			sleeping_q <= (state_d == sbs_pkg::ST_SLEEP);
		end
	end

	// ----------------------------------------
	// Burst counter and array address
	// ----------------------------------------
	sbs_burst_ctr u_ctr (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.load(load),
		.start(bus.addr[1:0]),
		.advance(advance),
		.linear(modeLinear_q),
		.nextOffset(nextOffset)
	);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			arrayAddr_q <= '0;
		end else if (load) begin
			arrayAddr_q <= bus.addr;
		end else if (advance) begin
			arrayAddr_q <= {arrayAddr_q[sbs_pkg::ADDR_W-1:2], nextOffset};
		end
	end

	// ----------------------------------------
	// Array write port
	// ----------------------------------------
	// Lane enables pulse for one cycle; the array keeps unselected lanes as they were
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			arrayLaneWe_q <= '0;
			arrayWrData_q <= '0;
		end else begin
			arrayLaneWe_q <= wrEn ? lanes : '0;
			if (wrEn) begin
				arrayWrData_q <= bus.sharedDataLines;
			end
		end
	end

	// ----------------------------------------
	// Data output
	// ----------------------------------------
	// Flow-through: read data passes straight from the array
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			drive_q <= 1'b0;
		end else begin
			drive_q <= drive;
		end
	end

	assign bus.devData = arrayRdData;
	assign bus.devDataOe = drive_q & ~bus.outEnableN;

	assign arrayAddr = arrayAddr_q;
	assign arrayLaneWe = arrayLaneWe_q;
	assign arrayWrData = arrayWrData_q;
	assign sleeping = sleeping_q;

endmodule : sbs_sram_end

// ---- hdl/sbs_ctrl_end.sv ----
`timescale 1ns/100ps
module sbs_ctrl_end (
	input wire logic ref_clk,
	input wire logic rstn,
	sbs_bus_if.host bus,
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [sbs_pkg::ADDR_W-1:0] cmdAddr,
	input wire logic [1:0] cmdLen,
	input wire logic [sbs_pkg::DATA_W-1:0] cmdWrData,
	input wire logic [sbs_pkg::LANES-1:0] cmdLanes,
	input wire logic modeLinear,
	input wire logic sleepCmd,
	output logic cmdReady,
	output logic rdValid,
	output logic [sbs_pkg::DATA_W-1:0] rdData,
	output logic asleep
);
	sbs_pkg::sbs_host_state_t st_q;
	logic [sbs_pkg::ADDR_W-1:0] addr_q;
	logic procStrobeN_q;
	logic ctrlStrobeN_q;
	logic advanceN_q;
	logic chipOn_q;
	logic wholeWriteN_q;
	logic laneWriteN_q;
	logic [sbs_pkg::LANES-1:0] laneSel_q;
	logic oe_q;
	logic sleep_q;
	logic [sbs_pkg::DATA_W-1:0] data_q;
	logic dataOe_q;
	logic [1:0] beat_q;
	logic [1:0] len_q;
	logic first_q;
	logic [2:0] cnt_q;
	logic ready_q;
	logic rdValid_q;
	logic [sbs_pkg::DATA_W-1:0] rdData_q;
	logic mode_q;
	logic capture;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Output enable stays high except in reads, so data is never driven against the SRAM
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= sbs_pkg::H_IDLE;
			addr_q <= '0;
			procStrobeN_q <= 1'b1;
			ctrlStrobeN_q <= 1'b1;
			advanceN_q <= 1'b1;
			chipOn_q <= 1'b0;
			wholeWriteN_q <= 1'b1;
			laneWriteN_q <= 1'b1;
			laneSel_q <= '1;
			oe_q <= 1'b1;
			sleep_q <= 1'b0;
			data_q <= '0;
			dataOe_q <= 1'b0;
			beat_q <= sbs_pkg::BEAT_RESET;
			len_q <= sbs_pkg::BEAT_RESET;
			first_q <= 1'b0;
			cnt_q <= sbs_pkg::COUNT_RESET;
			ready_q <= 1'b1;
		end else begin
			unique case (st_q)
				sbs_pkg::H_IDLE: begin
					if (sleepCmd) begin
						ctrlStrobeN_q <= 1'b0;
						chipOn_q <= 1'b0;
						ready_q <= 1'b0;
						st_q <= sbs_pkg::H_DESEL;
					end else if (cmdValid && ready_q) begin
						addr_q <= cmdAddr;
						chipOn_q <= 1'b1;
						len_q <= cmdLen;
						beat_q <= sbs_pkg::BEAT_RESET;
						if (cmdWrite) begin
							ctrlStrobeN_q <= 1'b0;
							wholeWriteN_q <= ~(&cmdLanes);
							laneWriteN_q <= &cmdLanes;
							laneSel_q <= ~cmdLanes;
							data_q <= cmdWrData;
							dataOe_q <= 1'b1;
							st_q <= sbs_pkg::H_WR;
						end else begin
							procStrobeN_q <= 1'b0;
							oe_q <= 1'b0;
							first_q <= 1'b1;
							ready_q <= 1'b0;
							st_q <= sbs_pkg::H_RD;
						end
					end
				end
				sbs_pkg::H_RD: begin
					procStrobeN_q <= 1'b1;
					chipOn_q <= 1'b0;
					advanceN_q <= 1'b0;
					first_q <= 1'b0;
					if (!first_q) begin
						beat_q <= beat_q + 2'h1;
						if (beat_q == len_q) begin
							advanceN_q <= 1'b1;
							oe_q <= 1'b1;
							ready_q <= 1'b1;
							st_q <= sbs_pkg::H_IDLE;
						end
					end
				end
				sbs_pkg::H_WR: begin
					ctrlStrobeN_q <= 1'b1;
					chipOn_q <= 1'b0;
					if (beat_q == len_q) begin
						wholeWriteN_q <= 1'b1;
						laneWriteN_q <= 1'b1;
						dataOe_q <= 1'b0;
						advanceN_q <= 1'b1;
						st_q <= sbs_pkg::H_IDLE;
					end else if (cmdValid) begin
						beat_q <= beat_q + 2'h1;
						wholeWriteN_q <= ~(&cmdLanes);
						laneWriteN_q <= &cmdLanes;
						laneSel_q <= ~cmdLanes;
						data_q <= cmdWrData;
						advanceN_q <= 1'b0;
					end else begin
						wholeWriteN_q <= 1'b1;
						laneWriteN_q <= 1'b1;
						advanceN_q <= 1'b1;
					end
				end
				sbs_pkg::H_DESEL: begin
					ctrlStrobeN_q <= 1'b1;
					sleep_q <= 1'b1;
					st_q <= sbs_pkg::H_SLEEP;
				end
				sbs_pkg::H_SLEEP: begin
					if (!sleepCmd) begin
						sleep_q <= 1'b0;
						cnt_q <= sbs_pkg::COUNT_RESET;
						st_q <= sbs_pkg::H_RECOVER;
					end
				end
				sbs_pkg::H_RECOVER: begin
					cnt_q <= cnt_q + 3'h1;
					if (cnt_q == 3'(sbs_pkg::HOST_WAKE_CYC - 1)) begin
						ready_q <= 1'b1;
						st_q <= sbs_pkg::H_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Read capture
	// ----------------------------------------
	assign capture = (st_q == sbs_pkg::H_RD) && !first_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdValid_q <= 1'b0;
			rdData_q <= '0;
			mode_q <= 1'b0;
		end else begin
			rdValid_q <= capture;
			mode_q <= modeLinear;
			if (capture) begin
				rdData_q <= bus.sharedDataLines;
			end
		end
	end

	assign bus.addr = addr_q;
	assign bus.procAddrStrobeN = procStrobeN_q;
	assign bus.ctrlAddrStrobeN = ctrlStrobeN_q;
	assign bus.burstAdvanceN = advanceN_q;
	assign bus.primaryChipSelN = ~chipOn_q;
	assign bus.secondaryChipSel = chipOn_q;
	assign bus.tertiaryChipSelN = ~chipOn_q;
	assign bus.wholeWordWriteN = wholeWriteN_q;
	assign bus.laneWriteEnableN = laneWriteN_q;
	assign bus.laneSelectN = laneSel_q;
	assign bus.outEnableN = oe_q;
	assign bus.sleepRequest = sleep_q;
	assign bus.burstLinear = mode_q;
	assign bus.hostData = data_q;
	assign bus.hostDataOe = dataOe_q;
	assign cmdReady = ready_q;
	assign rdValid = rdValid_q;
	assign rdData = rdData_q;
	assign asleep = sleep_q;

endmodule : sbs_ctrl_end

// ---- tb/sbs_bus_assertions.sv ----
`timescale 1ns/100ps
module sbs_bus_assertions (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ctrlAddrStrobeN,
	input wire logic procAddrStrobeN,
	input wire logic primaryChipSelN,
	input wire logic secondaryChipSel,
	input wire logic tertiaryChipSelN,
	input wire logic wholeWordWriteN,
	input wire logic laneWriteEnableN,
	input wire logic [sbs_pkg::LANES-1:0] laneSelectN,
	input wire logic outEnableN,
	input wire logic sleepRequest,
	input wire logic hostDataOe,
	input wire logic devDataOe
);
	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	logic enabled;
	logic writeIn;
	assign enabled = !primaryChipSelN && secondaryChipSel && !tertiaryChipSelN;
	assign writeIn = !wholeWordWriteN || (!laneWriteEnableN && laneSelectN != 4'hf);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence procRead;
		!procAddrStrobeN && enabled && !sleepRequest ##1 !outEnableN;
	endsequence
	sequence ctrlWrite;
		!ctrlAddrStrobeN && procAddrStrobeN && enabled && writeIn;
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_OE_GATE: assert property (devDataOe |-> !outEnableN)
		else $error("data driven while output enable high");
	AST_WRITE_FLOAT: assert property (hostDataOe |-> !devDataOe)
		else $error("device drives during host write data");
	AST_CTRL_WRITE: assert property (ctrlWrite |=> !devDataOe)
		else $error("device drives after controller write start");
	AST_READ_DRIVE: assert property (procRead |-> devDataOe)
		else $error("read data not driven");
	AST_OE_BEFORE_DATA: assert property ($rose(hostDataOe) |-> $past(outEnableN))
		else $error("write data driven before output enable high");
	AST_SLEEP_FLOAT: assert property (sleepRequest [*6] |-> !devDataOe)
		else $error("data driven while asleep");
	AST_DESEL_SLEEP: assert property ($rose(sleepRequest) |-> !enabled && procAddrStrobeN)
		else $error("sleep asserted while selected");
	AST_RECOVERY: assert property ($fell(sleepRequest) |-> (procAddrStrobeN && ctrlAddrStrobeN && !enabled) [*2])
		else $error("strobe or enable during sleep recovery");
endmodule : sbs_bus_assertions

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	// ----------------------------------------
	// Design, array model and clock
	// ----------------------------------------
	typedef struct {logic w; logic [17:0] a; logic [1:0] n; logic [35:0] d; logic [3:0] ln; logic lin;} sbs_row_t;
	logic ref_clk, rstn, cmdValid, cmdWrite, modeLinear, sleepCmd, cmdReady, rdValid, asleep, sleeping;
	logic [17:0] cmdAddr, arrayAddr;
	logic [1:0] cmdLen;
	logic [3:0] cmdLanes, arrayLaneWe;
	logic [35:0] cmdWrData, rdData, arrayWrData, arrayRdData;
	logic [35:0] mem [64];
	logic [35:0] expMem [64];
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	sbs_row_t rows [8] = '{
		'{1'b1, 18'h01, 2'h3, 36'h123456789, 4'hf, 1'b1}, '{1'b0, 18'h01, 2'h3, 36'h0, 4'h0, 1'b1},
		'{1'b1, 18'h06, 2'h3, 36'h0abcdef01, 4'hf, 1'b0}, '{1'b0, 18'h06, 2'h3, 36'h0, 4'h0, 1'b0},
		'{1'b1, 18'h02, 2'h0, 36'hfffffffff, 4'h5, 1'b1}, '{1'b1, 18'h03, 2'h1, 36'h0, 4'h0, 1'b0},
		'{1'b0, 18'h00, 2'h3, 36'h0, 4'h0, 1'b1}, '{1'b0, 18'h03, 2'h1, 36'h0, 4'h0, 1'b0}};
	sbs_bus_if sbs_bus_if_i ();
	sbs_sram_end sbs_sram_end_i (.ref_clk(ref_clk), .rstn(rstn), .bus(sbs_bus_if_i.dev), .arrayAddr(arrayAddr),
		.arrayLaneWe(arrayLaneWe), .arrayWrData(arrayWrData), .arrayRdData(arrayRdData), .sleeping(sleeping));
	sbs_ctrl_end sbs_ctrl_end_i (.ref_clk(ref_clk), .rstn(rstn), .bus(sbs_bus_if_i.host), .cmdValid(cmdValid),
		.cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdLen(cmdLen), .cmdWrData(cmdWrData), .cmdLanes(cmdLanes),
		.modeLinear(modeLinear), .sleepCmd(sleepCmd), .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData),
		.asleep(asleep));
	sbs_bus_assertions sbs_bus_assertions_i (.ref_clk(ref_clk), .rstn(rstn),
		.ctrlAddrStrobeN(sbs_bus_if_i.ctrlAddrStrobeN), .procAddrStrobeN(sbs_bus_if_i.procAddrStrobeN),
		.primaryChipSelN(sbs_bus_if_i.primaryChipSelN), .secondaryChipSel(sbs_bus_if_i.secondaryChipSel),
		.tertiaryChipSelN(sbs_bus_if_i.tertiaryChipSelN), .wholeWordWriteN(sbs_bus_if_i.wholeWordWriteN),
		.laneWriteEnableN(sbs_bus_if_i.laneWriteEnableN), .laneSelectN(sbs_bus_if_i.laneSelectN),
		.outEnableN(sbs_bus_if_i.outEnableN), .sleepRequest(sbs_bus_if_i.sleepRequest),
		.hostDataOe(sbs_bus_if_i.hostDataOe), .devDataOe(sbs_bus_if_i.devDataOe));
	// Small array: only the low address bits matter to these tests
	assign arrayRdData = mem[arrayAddr[5:0]];
	always @(posedge ref_clk) begin
		for (int l = 0; l < sbs_pkg::LANES; l++) begin
			if (arrayLaneWe[l]) mem[arrayAddr[5:0]][l*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] <= arrayWrData[l*9 +: 9];
		end
	end
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Whole run needs a few hundred cycles; ceiling leaves wide margin
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			final_report();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	task automatic run(input sbs_row_t r);
		logic [5:0] idx;
		int t;
		modeLinear = r.lin;
		repeat (8) @(negedge ref_clk);
		cmdWrite = r.w;
		cmdAddr = r.a;
		cmdLen = r.n;
		cmdWrData = r.d;
		cmdLanes = r.ln;
		cmdValid = 1'b1;
		@(negedge ref_clk);
		if (!r.w) cmdValid = 1'b0;
		for (int k = 0; k <= r.n; k++) begin
			idx = {r.a[5:2], r.lin ? r.a[1:0] + 2'(k) : r.a[1:0] ^ 2'(k)};
			if (r.w) begin
				// Unselected lanes keep their old contents; each beat carries its own word
				for (int l = 0; l < 4; l++) if (r.ln[l]) expMem[idx][l*9 +: 9] = cmdWrData[l*9 +: 9];
				if (k < r.n) begin
					cmdWrData = r.d ^ 36'(k + 1);
					@(negedge ref_clk);
				end
			end else begin
				t = 0;
				do begin
					@(negedge ref_clk);
					t++;
				end while (rdValid !== 1'b1 && t < 20);
				check("read beat spacing", 36'(t), (k == 0) ? 36'h2 : 36'h1);
				check("burst read data", rdData, expMem[idx]);
			end
		end
		cmdValid = 1'b0;
		repeat (3) @(negedge ref_clk);
		check("ready after command", {35'h0, cmdReady}, 36'h1);
		$display("Test done: %s at %h", r.w ? "write" : "read", r.a);
	endtask : run
	task automatic reset_check();
		check("ready in reset", {35'h0, cmdReady}, 36'h1);
		check("read valid in reset", {35'h0, rdValid}, 36'h0);
		check("sleeping in reset", {35'h0, sleeping}, 36'h0);
		check("device drive in reset", {35'h0, sbs_bus_if_i.devDataOe}, 36'h0);
		check("lane writes in reset", {32'h0, arrayLaneWe}, 36'h0);
	endtask : reset_check
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int t;
		rstn = 1'b0;
		{cmdValid, cmdWrite, modeLinear, sleepCmd} = 4'h0;
		cmdAddr = 18'h0;
		cmdLen = 2'h0;
		cmdWrData = 36'h0;
		cmdLanes = 4'h0;
		for (int i = 0; i < 64; i++) begin
			mem[i] = 36'h0;
			expMem[i] = 36'h0;
		end
		repeat (10) @(negedge ref_clk);
		reset_check();
		$display("Test done: reset values");
		rstn = 1'b1;
		foreach (rows[i]) run(rows[i]);
		// Write burst with a stalled beat: the counter must hold through the gap
		cmdWrite = 1'b1;
		cmdAddr = 18'h08;
		cmdLen = 2'h1;
		cmdLanes = 4'hf;
		cmdWrData = 36'h111111111;
		cmdValid = 1'b1;
		@(negedge ref_clk);
		cmdValid = 1'b0;
		@(negedge ref_clk);
		cmdWrData = 36'h222222222;
		cmdValid = 1'b1;
		@(negedge ref_clk);
		cmdValid = 1'b0;
		expMem[8] = 36'h111111111;
		expMem[9] = 36'h222222222;
		run('{1'b0, 18'h08, 2'h1, 36'h0, 4'h0, 1'b0});
		// Sleep entry, contents kept across it, then wake
		sleepCmd = 1'b1;
		t = 0;
		while (sleeping !== 1'b1 && t < 30) begin
			@(negedge ref_clk);
			t++;
		end
		check("sleeping", {35'h0, sleeping}, 36'h1);
		check("host asleep", {35'h0, asleep}, 36'h1);
		// Deselect, pin flop, sync, level and decode, then the entry cycles
		check("cycles to sleep", 36'(t), 36'(4 + sbs_pkg::SYNC_STAGES + sbs_pkg::SLEEP_ENTRY_CYC));
		sleepCmd = 1'b0;
		repeat (sbs_pkg::SLEEP_RECOVERY_CYC + 1) @(negedge ref_clk);
		check("ready during recovery", {35'h0, cmdReady}, 36'h0);
		repeat (17) @(negedge ref_clk);
		check("awake", {35'h0, sleeping}, 36'h0);
		check("ready after wake", {35'h0, cmdReady}, 36'h1);
		$display("Test done: sleep and wake");
		run(rows[6]);
		// Second reset in mid-run keeps array, clears bus state
		rstn = 1'b0;
		repeat (2) @(negedge ref_clk);
		reset_check();
		$display("Test done: reset in mid-run");
		rstn = 1'b1;
		run(rows[3]);
		final_report();
	end
endmodule : testbench
